// *** output_strobe_assign_reg.sv ***
/*
  Step-assignment register bank for two general outputs, reached over Avalon-MM with waitrequest.
  Assumes a sequencer outside that pulses seq_strobe with the step reached and the direction,
  and a seal flag and backup-present level from the power path.
*/
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`include "output_strobe_assign_map.svh"
module output_strobe_assign_reg (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [3:0] seq_step,
  input wire logic seq_strobe,
  input wire logic seq_power_up,
  input wire logic factory_seal_flag,
  input wire logic backup_present,
  output logic general_output_one,
  output logic general_output_three
);
  output_strobe_assign_pkg::bus_state_t bus_state_r;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [7:0] assign_r;
  logic unlock_r;
  logic [1:0] host_out_r;
  logic [1:0] out_r;
  logic [5:0] idx;
  logic commit_wr;
  logic assign_wr;
  logic [31:0] read_mux;

  step_match_if ch ();

  step_matcher u_matcher (
    .ch(ch)
  );

  assign idx = address[7:2];
  // A write takes effect only at the edge where waitrequest is seen low
  assign commit_wr = write && (bus_state_r == output_strobe_assign_pkg::BUS_ACK);
  assign assign_wr = commit_wr && (idx == `ASSIGN_IDX) && byteenable[0];

  assign ch.code[0] = assign_r[`OUT1_LSB +: 4];
  assign ch.code[1] = assign_r[`OUT3_LSB +: 4];
  assign ch.host_val = host_out_r;
  assign ch.cur = out_r;
  assign ch.step = seq_step;
  assign ch.strobe = seq_strobe;
  assign ch.power_up = seq_power_up;

  // Bus handshake: one wait cycle, then the answer for exactly one edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_state_r <= output_strobe_assign_pkg::BUS_IDLE;
      waitrequest_r <= 1'b1;
    end else begin
      case (bus_state_r)
        output_strobe_assign_pkg::BUS_IDLE: begin
          if (read || write) begin
            bus_state_r <= output_strobe_assign_pkg::BUS_ACK;
            waitrequest_r <= 1'b0;
          end
        end
        output_strobe_assign_pkg::BUS_ACK: begin
          bus_state_r <= output_strobe_assign_pkg::BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
        default: begin
          bus_state_r <= output_strobe_assign_pkg::BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    case (idx)
      `ASSIGN_IDX: read_mux = {24'h00_0000, assign_r};
      `UNLOCK_IDX: read_mux = {31'h0000_0000, unlock_r};
      `HOST_OUT_IDX: read_mux = {30'h0000_0000, host_out_r};
      // Seal reads as its raw level; bit 1 tells software whether it means anything
      `STATUS_IDX: read_mux = {26'h000_0000, out_r, ch.controlled, backup_present, factory_seal_flag};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // Read data is latched while waitrequest is high so it stands at the answer edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readdata_r <= 32'h0000_0000;
    end else if (read && (bus_state_r == output_strobe_assign_pkg::BUS_IDLE)) begin
      readdata_r <= read_mux;
    end
  end

  // Key arms one write to the assignment register; any other key value disarms
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unlock_r <= 1'b0;
    end else if (commit_wr && (idx == `UNLOCK_IDX) && byteenable[0]) begin
      unlock_r <= (writedata[7:0] == `UNLOCK_KEY);
    end else if (assign_wr) begin
      unlock_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      assign_r <= `ASSIGN_RESET;
    end else if (assign_wr && unlock_r) begin
      assign_r <= writedata[7:0];
    end
  end

  // Host value reaches an output only while that output's code leaves it uncontrolled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_out_r <= 2'h0;
    end else if (commit_wr && (idx == `HOST_OUT_IDX) && byteenable[0]) begin
      host_out_r <= writedata[1:0];
    end
  end

  // Both pins come from flops so a code write or step change never glitches them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_r <= 2'h0;
    end else begin
      out_r <= ch.nxt;
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign general_output_one = out_r[0];
  assign general_output_three = out_r[1];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence bus_req_seen;
    (read || write) && (bus_state_r == output_strobe_assign_pkg::BUS_IDLE);
  endsequence

  sequence bus_answer_once;
    !waitrequest_r ##1 waitrequest_r;
  endsequence

  a_bus_one_wait: assert property (bus_req_seen |=> bus_answer_once)
    else $error("bus answer not one cycle after request");

  a_reset_value: assert property (@(posedge sys_clk) $past(rst) |-> (assign_r == 8'h03))
    else $error("assignment register not at reset value");

  a_locked_write_dropped: assert property (assign_wr && !unlock_r |=> $stable(assign_r))
    else $error("locked write changed assignment register");

  a_unlocked_write_taken: assert property (assign_wr && unlock_r |=> (assign_r == $past(writedata[7:0]))
                                           ##0 !unlock_r)
    else $error("unlocked write not taken or unlock not consumed");

  // Commit points of the key and host registers, and the edge at which a read is taken
  sequence key_commit;
    commit_wr && (idx == `UNLOCK_IDX) && byteenable[0] && (writedata[7:0] == `UNLOCK_KEY);
  endsequence

  sequence host_commit;
    commit_wr && (idx == `HOST_OUT_IDX) && byteenable[0];
  endsequence

  sequence read_taken;
    read && (bus_state_r == output_strobe_assign_pkg::BUS_IDLE);
  endsequence

  a_key_arms_write: assert property (key_commit |=> unlock_r)
    else $error("unlock key did not arm the assignment register");

  // One-shot: any assignment write with byte lane 0 on clears the key, accepted or not; one with lane 0 off leaves it armed
  a_unlock_consumed: assert property (assign_wr |=> !unlock_r)
    else $error("unlock survived an assignment write");

  a_host_write_lands: assert property (host_commit |=> (host_out_r == $past(writedata[1:0])))
    else $error("host output value not written");

  a_assign_reads_back: assert property (read_taken ##0 (idx == `ASSIGN_IDX) |=>
                                        (readdata == {24'h00_0000, $past(assign_r)}))
    else $error("assignment register read back wrong");

  // Seal level is passed raw; only software knows whether the backup path makes it meaningful
  a_status_raw_seal: assert property (read_taken ##0 (idx == `STATUS_IDX) |=>
                                      (readdata[1:0] == $past({backup_present, factory_seal_flag})))
    else $error("status read does not carry seal and backup levels");

  a_no_request_no_answer: assert property (!(read || write) && (bus_state_r == output_strobe_assign_pkg::BUS_IDLE)
                                           |=> waitrequest_r)
    else $error("bus answered without a request");

  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_chk
      a_step_switches_on: assert property (seq_strobe && seq_power_up && (seq_step == ch.code[k]) &&
                                           (ch.code[k] >= 4'h3) && (ch.code[k] <= 4'hA) |=> out_r[k])
        else $error("output not enabled at its step");
      a_decode_range: assert property (ch.controlled[k] == ((ch.code[k] >= 4'h3) && (ch.code[k] <= 4'hA)))
        else $error("step code range decoded wrongly");
      a_low_codes_free: assert property ((ch.code[k] <= 4'h2) |=> (out_r[k] == $past(host_out_r[k])))
        else $error("low code output under sequencer control");
      a_high_codes_free: assert property ((ch.code[k] >= 4'hB) |=> (out_r[k] == $past(host_out_r[k])))
        else $error("high code output under sequencer control");
      a_match_powers_down: assert property (seq_strobe && !seq_power_up && (seq_step == ch.code[k]) &&
                                            ch.controlled[k] |=> !out_r[k])
        else $error("output not disabled at its power-down step");
      a_no_match_holds: assert property (ch.controlled[k] && !(seq_strobe && (seq_step == ch.code[k]))
                                         |=> (out_r[k] == $past(out_r[k])))
        else $error("controlled output changed without a matching step");
    end
  endgenerate
endmodule

// *** output_strobe_assign_map.svh ***
/*
  Offsets, field positions, reset values and codes of the output step-assignment register bank.
  Assumes a 32-bit Avalon-MM byte address: the byte address is four times each register index.
*/
// How it works
// - The 8-bit assignment register sits at index 0x26, resets to 0x3, and holds output three's step code in bits 7-4 and output one's in bits 3-0.
// - The assignment register takes a write only after the unlock key has been written, and the host must unlock before it changes a field.
// - Codes 3h to Ah in a field select steps 3 to 10, and the output is switched when the sequencer reaches that step.
// - Codes 0h, 1h and 2h leave the output out of sequencer control in both power-up and power-down.
// - Codes Bh to Fh also leave the output out of sequencer control and map to no step.
`ifndef OUTPUT_STROBE_ASSIGN_MAP_SVH
`define OUTPUT_STROBE_ASSIGN_MAP_SVH
`define ASSIGN_IDX 6'h26
`define UNLOCK_IDX 6'h10
`define HOST_OUT_IDX 6'h11
`define STATUS_IDX 6'h12
`define ASSIGN_RESET 8'h03
`define OUT3_LSB 4
`define OUT1_LSB 0
`define STEP_FIRST 4'h3
`define STEP_LAST 4'hA
`define UNLOCK_KEY 8'h7D
`endif

// *** output_strobe_assign_pkg.sv ***
/*
  Types shared by the step-assignment bank.
  Assumes the map header supplies all numeric constants.
*/
package output_strobe_assign_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;
  typedef logic [3:0] step_code_t;
endpackage

// *** step_match_if.sv ***
/*
  Carrier between the register bank and the per-output step matcher.
  Assumes both ends share sys_clk; the matcher is purely combinational.
*/
`timescale 1ns/10ps
interface step_match_if;
  output_strobe_assign_pkg::step_code_t [1:0] code;
  logic [1:0] host_val;
  logic [1:0] cur;
  logic [3:0] step;
  logic strobe;
  logic power_up;
  logic [1:0] controlled;
  logic [1:0] nxt;
  modport bank (output code, output host_val, output cur, output step, output strobe, output power_up,
                input controlled, input nxt);
  modport matcher (input code, input host_val, input cur, input step, input strobe, input power_up,
                   output controlled, output nxt);
endinterface

// *** step_matcher.sv ***
/*
  Per-output decode of the 4-bit step code and next output level.
  Assumes the sequencer strobe is a one-cycle pulse carrying the step just reached.
*/
`timescale 1ns/10ps
`include "output_strobe_assign_map.svh"
module step_matcher (
  step_match_if.matcher ch
);
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      logic in_range;
      // Codes below 3h and above Ah are both uncontrolled
      assign in_range = (ch.code[i] >= `STEP_FIRST) && (ch.code[i] <= `STEP_LAST);
      assign ch.controlled[i] = in_range;
      always_comb begin
        if (!in_range) begin
          ch.nxt[i] = ch.host_val[i];
        end else if (ch.strobe && (ch.step == ch.code[i])) begin
          ch.nxt[i] = ch.power_up;
        end else begin
          ch.nxt[i] = ch.cur[i];
        end
      end
    end
  endgenerate
endmodule

// *** testbench.sv ***
/*
  Self-checking bench for the output step-assignment bank.
  Assumes the map header and package are compiled first; the bench drives every port.
*/
`timescale 1ns/10ps
`include "output_strobe_assign_map.svh"
module testbench;
  localparam logic [7:0] ASSIGN_ADDR = {`ASSIGN_IDX, 2'b00};
  localparam logic [7:0] UNLOCK_ADDR = {`UNLOCK_IDX, 2'b00};
  localparam logic [7:0] HOST_ADDR = {`HOST_OUT_IDX, 2'b00};
  localparam logic [7:0] STATUS_ADDR = {`STATUS_IDX, 2'b00};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] seq_step = 4'h0;
  logic seq_strobe = 1'b0;
  logic seq_power_up = 1'b0;
  logic factory_seal_flag = 1'b0;
  logic backup_present = 1'b0;
  logic general_output_one;
  logic general_output_three;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int i;
  logic b;
  logic [3:0] c;
  logic [31:0] r;
  logic [31:0] rdat;
  logic [31:0] st;
  logic [31:0] seed = 32'h9df8_0f64;

  output_strobe_assign_reg dut_u (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .seq_step(seq_step), .seq_strobe(seq_strobe), .seq_power_up(seq_power_up),
    .factory_seal_flag(factory_seal_flag), .backup_present(backup_present),
    .general_output_one(general_output_one), .general_output_three(general_output_three));

  always #25 sys_clk = ~sys_clk;

  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      end_of_test();
    end
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic ctl(input logic [3:0] code);
    return (code >= `STEP_FIRST) && (code <= `STEP_LAST);
  endfunction

  function logic exp_out(input logic [3:0] code, input logic pu, input logic hv);
    return ctl(code) ? pu : hv;
  endfunction

  task end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task strobe(input logic [3:0] s, input logic pu);
    @(posedge sys_clk);
    seq_step <= s;
    seq_strobe <= 1'b1;
    seq_power_up <= pu;
    @(posedge sys_clk);
    seq_strobe <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, ASSIGN_ADDR, 32'h0000_0000);
    cmp_word("assign reset", 32'h0000_0003, rdat);
    bus(1'b1, ASSIGN_ADDR, 32'h0000_00A5);
    bus(1'b0, ASSIGN_ADDR, 32'h0000_0000);
    cmp_word("assign locked", 32'h0000_0003, rdat);
    // Key followed by a wrong value must leave the register locked
    bus(1'b1, UNLOCK_ADDR, 32'h0000_007D);
    bus(1'b0, UNLOCK_ADDR, 32'h0000_0000);
    cmp_word("unlock armed", 32'h0000_0001, rdat);
    bus(1'b1, UNLOCK_ADDR, 32'h0000_0011);
    bus(1'b0, UNLOCK_ADDR, 32'h0000_0000);
    cmp_word("unlock disarmed", 32'h0000_0000, rdat);
    bus(1'b1, ASSIGN_ADDR, 32'h0000_00A5);
    bus(1'b0, ASSIGN_ADDR, 32'h0000_0000);
    cmp_word("assign disarmed", 32'h0000_0003, rdat);
    // Byte lane 0 off: even an unlocked write must not land
    bus(1'b1, UNLOCK_ADDR, 32'h0000_007D);
    byteenable <= 4'h0;
    bus(1'b1, ASSIGN_ADDR, 32'h0000_00A5);
    byteenable <= 4'hF;
    bus(1'b0, ASSIGN_ADDR, 32'h0000_0000);
    cmp_word("assign lane off", 32'h0000_0003, rdat);
    for (i = 0; i < 16; i++) begin
      r = rnd();
      b = r[0];
      c = 4'hF - i[3:0];
      factory_seal_flag <= r[1];
      backup_present <= r[2];
      bus(1'b1, HOST_ADDR, {30'h0, b, b});
      bus(1'b1, UNLOCK_ADDR, 32'h0000_007D);
      bus(1'b1, ASSIGN_ADDR, {24'h00_0000, c, i[3:0]});
      bus(1'b0, ASSIGN_ADDR, 32'h0000_0000);
      cmp_word("assign value", {24'h00_0000, c, i[3:0]}, rdat);
      // Second strobe never matches output one's code, so a controlled output must hold
      strobe(i[3:0], ~b);
      strobe(c, ~b);
      repeat (2) @(posedge sys_clk);
      cmp_bit("output one", exp_out(i[3:0], ~b, b), general_output_one);
      cmp_bit("output three", exp_out(c, ~b, b), general_output_three);
      bus(1'b0, HOST_ADDR, 32'h0000_0000);
      cmp_word("host value", {30'h0, b, b}, rdat);
      bus(1'b0, STATUS_ADDR, 32'h0000_0000);
      st = {26'h0, exp_out(c, ~b, b), exp_out(i[3:0], ~b, b), ctl(c), ctl(i[3:0]), r[2], r[1]};
      cmp_word("status word", st, rdat);
    end
    bus(1'b0, 8'hFC, 32'h0000_0000);
    cmp_word("unmapped read", 32'h0000_0000, rdat);
    // Reset in mid-run must bring the register and both outputs back to their reset state
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, ASSIGN_ADDR, 32'h0000_0000);
    cmp_word("assign after reset", 32'h0000_0003, rdat);
    cmp_bit("output one after reset", 1'b0, general_output_one);
    cmp_bit("output three after reset", 1'b0, general_output_three);
    end_of_test();
  end
endmodule
